// ===== gpcp_board_model.sv
/*
  Board circuitry at the pads: the pin level comes from the block's
  driver, an external source that the bench controls, or the pull-up.
  Assumes the bench never drives a pad whose output enable is high.
*/
module gpcp_board_model
(
  input  wire logic        hclk,
  input  wire logic [10:0] pin_out,
  input  wire logic [10:0] pin_oe,
  input  wire logic [10:0] pin_pullup,
  input  wire logic [10:0] ext_drv,
  input  wire logic [10:0] ext_val,
  output logic      [10:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // A floating pad flips every cycle so a stale level never passes
  logic [10:0] last_ff = 11'h000;
  // Start from a known zero, so toggling on its own history never locks the pad at unknown
  always @(posedge hclk) last_ff <= ~last_ff;
  // Released open-drain pad falls to the pull-up or floats
  always_comb
    for (int i = 0; i < 11; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] :
                  pin_pullup[i] ? 1'h1 : ~last_ff[i];
endmodule

// ===== gpcp_gpio_pin_config_port.sv
/*
  Pin configuration bank for P0.7, P1.0-P1.7 and P2.0-P2.1 behind an
  AHB-Lite slave, with per-pin edge interrupt detection and the shared
  USB, clock-output and serial takeovers.
  Assumes the pin pads resolve out/oe/pull-up, pin inputs are already
  synchronous to hclk, and port data, serial engine and USB transceiver
  live outside and feed their signals in.
*/
// The AHB-Lite slave port was left to the implementer.

// Overview of operation
// RL1: USB enabled makes P1.0/P1.1 registers ineffective
// RL2: P1.0 output only pulls low or releases
// RL3: Shared lift bit pulls up P1.0 and P1.1
// RL4: Bit 0 enables P1.0 and P1.1 drivers
// RL5: P1.1 pull-up comes only from shared bit
// RL6: P1.2 bit 7 routes clock to pin
// RL7: Serial logic drives P1.3 while serial enabled
// RL8: P1.3 to P1.7 always TTL thresholds
// RL9: P1.4-P1.6 serial drive needs alternate bit set
// RL10: Pin options apply in serial and GPIO roles
// RL11: Serial sets direction of P1.3, P1.5, P1.6
// RL12: Firmware sets P1.4 direction in serial role
// RL13: P0.7 register with bits 7 and 3 reserved
// RL14: One port 2 register controls both pins
// RL15: Firmware parks unbonded pins in defined state
// RL16: Firmware masks unbonded bits of port 0
// RL17: Enabled pin raises edge interrupt either direction
// RL18: Polarity bit set means falling edge
// RL19: Open-drain releases on one, drives low zero
// RL20: Output enable bit turns driver on
// RL21: All configuration registers reset to zero
module gpcp_gpio_pin_config_port
  import gpcp_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        usb_en,
  input  wire logic [1:0]  spi_mode,
  input  wire logic [3:0]  spi_oe,
  input  wire logic [3:0]  spi_out,
  input  wire logic        clk_src,
  input  wire logic [10:0] gpio_data,
  input  wire logic [10:0] pin_in,
  output logic      [10:0] pin_out,
  output logic      [10:0] pin_oe,
  output logic      [10:0] pin_pullup,
  output logic      [10:0] pin_ttl,
  output logic      [10:0] pin_high_sink,
  output logic      [10:0] pin_drive_3v3,
  output logic      [10:0] pin_irq
);

  // ************************************************************
  // Bus decode
  // ************************************************************

  logic [7:0]  cfg_ff [GPCP_NUM_REGS];
  logic [7:0]  wmask  [GPCP_NUM_REGS];
  logic        wr_pend_ff;
  logic [3:0]  wr_slot_ff;
  logic [31:0] hrdata_ff;
  logic [10:0] prev_in_ff;
  logic [10:0] irq_ff;

  wire         addr_take;
  wire         idx_hit;
  wire  [5:0]  idx;
  wire  [5:0]  slot_wide;
  wire  [3:0]  slot;
  wire  [7:0]  wr_byte;
  wire  [7:0]  rd_byte;
  wire  [31:0] nxt_hrdata;

  // Address phase taken only on a valid transfer while the bus is ready
  assign addr_take = hsel & hready & htrans[1];
  assign idx       = haddr[7:2];
  assign idx_hit   = (haddr[31:8] == 24'h000000) &&
                     (idx >= GPCP_IDX_FIRST) && (idx <= GPCP_IDX_LAST);
  assign slot_wide = idx - GPCP_IDX_FIRST;
  assign slot      = slot_wide[3:0];
  assign wr_byte   = hwdata[7:0] & wmask[wr_slot_ff];

  // Write masks hold reserved bits at zero
  assign wmask[0] = GPCP_MASK_P0_PIN7; // RL13
  assign wmask[1] = GPCP_MASK_USB_PLUS;
  assign wmask[2] = GPCP_MASK_USB_MINUS; // RL5
  assign wmask[3] = GPCP_MASK_P1_PIN2;
  assign wmask[4] = GPCP_MASK_P1_PIN3;
  assign wmask[5] = GPCP_MASK_P1_SPI;
  assign wmask[6] = GPCP_MASK_P1_SPI;
  assign wmask[7] = GPCP_MASK_P1_SPI;
  assign wmask[8] = GPCP_MASK_P1_PIN7;
  assign wmask[9] = GPCP_MASK_PORT2; // RL14

  // Forward a write still in its data phase so a read never sees stale data
  assign rd_byte    = (wr_pend_ff && (wr_slot_ff == slot)) ? wr_byte
                                                           : cfg_ff[slot];
  assign nxt_hrdata = (addr_take && !hwrite && idx_hit)
                      ? {24'h000000, rd_byte} : 32'h00000000;

  // Zero wait states; every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // ************************************************************
  // Register file
  // ************************************************************

  // Pending write: captured in address phase, applied in data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_slot_ff <= 4'h0;
      hrdata_ff  <= 32'h00000000;
    end
    else
    begin
      wr_pend_ff <= addr_take & hwrite & idx_hit;
      wr_slot_ff <= slot;
      hrdata_ff  <= nxt_hrdata;
    end
  end

  // Configuration bytes; unmapped writes fall away silently
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int r = 0; r < GPCP_NUM_REGS; r++)
      begin
        cfg_ff[r] <= GPCP_CFG_RESET; // RL21
      end
    end
    else if (wr_pend_ff)
    begin
      cfg_ff[wr_slot_ff] <= wr_byte;
    end
  end

  // ************************************************************
  // Per-pin configuration view
  // ************************************************************

  wire [7:0] cfg_pin [GPCP_NUM_PINS];
  wire       spi_active;
  wire       clk_route;
  wire [3:0] spi_take;
  wire [10:0] data_sel;
  wire [10:0] drv_sel;
  wire [10:0] od_sel;
  wire [10:0] int_en;
  wire [10:0] rise;
  wire [10:0] fall;

  // Pins 0..8 map one to one onto slots; both port 2 pins share slot 9
  genvar g;
  generate
    for (g = 0; g < GPCP_PIN_P20; g++)
    begin : g_cfg
      assign cfg_pin[g] = cfg_ff[g];
    end
  endgenerate
  assign cfg_pin[GPCP_PIN_P20] = cfg_ff[9]; // RL14
  assign cfg_pin[GPCP_PIN_P21] = cfg_ff[9]; // RL14

  // Serial engine counts as enabled only in master or slave role
  assign spi_active = (spi_mode == GPCP_SPI_MASTER) ||
                      (spi_mode == GPCP_SPI_SLAVE);
  assign clk_route  = cfg_pin[GPCP_PIN_P12][GPCP_BIT_ALT];
  // P1.3 has no alternate bit, so it follows the engine alone
  assign spi_take[0] = spi_active; // RL7
  assign spi_take[1] = spi_active & cfg_pin[5][GPCP_BIT_ALT]; // RL9
  assign spi_take[2] = spi_active & cfg_pin[6][GPCP_BIT_ALT]; // RL9
  assign spi_take[3] = spi_active & cfg_pin[7][GPCP_BIT_ALT]; // RL9

  // ************************************************************
  // Output source, driver enable and open-drain selection
  // ************************************************************

  // P0.7 plain GPIO
  assign data_sel[0] = gpio_data[0];
  assign drv_sel[0]  = cfg_pin[0][GPCP_BIT_OUT_EN]; // RL20
  assign od_sel[0]   = cfg_pin[0][GPCP_BIT_OPEN_DR];

  // USB lines: driver only while USB is off; never sources a high
  assign data_sel[1] = gpio_data[1];
  assign drv_sel[1]  = ~usb_en & cfg_pin[1][GPCP_BIT_OUT_EN]; // RL1 RL4
  assign od_sel[1]   = 1'b1; // RL2
  assign data_sel[2] = gpio_data[2];
  assign drv_sel[2]  = ~usb_en & cfg_pin[2][GPCP_BIT_OUT_EN]; // RL1 RL4
  assign od_sel[2]   = 1'b1; // No sourcing capability on this line

  // P1.2: clock output overrides the GPIO driver
  assign data_sel[3] = clk_route ? clk_src : gpio_data[3]; // RL6
  assign drv_sel[3]  = clk_route | cfg_pin[3][GPCP_BIT_OUT_EN]; // RL6
  assign od_sel[3]   = ~clk_route & cfg_pin[3][GPCP_BIT_OPEN_DR];

  // P1.3: serial engine owns level and direction while active
  assign data_sel[4] = spi_take[0] ? spi_out[0] : gpio_data[4]; // RL7
  assign drv_sel[4]  = spi_take[0] ? spi_oe[0]             // RL11
                                   : cfg_pin[4][GPCP_BIT_OUT_EN];
  assign od_sel[4]   = cfg_pin[4][GPCP_BIT_OPEN_DR]; // RL10

  // P1.4: level from engine, direction always from firmware
  assign data_sel[5] = spi_take[1] ? spi_out[1] : gpio_data[5]; // RL9
  assign drv_sel[5]  = cfg_pin[5][GPCP_BIT_OUT_EN]; // RL11 RL12
  assign od_sel[5]   = cfg_pin[5][GPCP_BIT_OPEN_DR]; // RL10

  // P1.5 and P1.6: engine sets direction too
  assign data_sel[6] = spi_take[2] ? spi_out[2] : gpio_data[6]; // RL9
  assign drv_sel[6]  = spi_take[2] ? spi_oe[2]             // RL11
                                   : cfg_pin[6][GPCP_BIT_OUT_EN];
  assign od_sel[6]   = cfg_pin[6][GPCP_BIT_OPEN_DR]; // RL10
  assign data_sel[7] = spi_take[3] ? spi_out[3] : gpio_data[7]; // RL9
  assign drv_sel[7]  = spi_take[3] ? spi_oe[3]             // RL11
                                   : cfg_pin[7][GPCP_BIT_OUT_EN];
  assign od_sel[7]   = cfg_pin[7][GPCP_BIT_OPEN_DR]; // RL10

  // P1.7 and port 2 pins: plain GPIO
  assign data_sel[8]  = gpio_data[8];
  assign drv_sel[8]   = cfg_pin[8][GPCP_BIT_OUT_EN];
  assign od_sel[8]    = cfg_pin[8][GPCP_BIT_OPEN_DR];
  assign data_sel[9]  = gpio_data[9];
  assign drv_sel[9]   = cfg_pin[9][GPCP_BIT_OUT_EN]; // RL14
  assign od_sel[9]    = cfg_pin[9][GPCP_BIT_OPEN_DR];
  assign data_sel[10] = gpio_data[10];
  assign drv_sel[10]  = cfg_pin[10][GPCP_BIT_OUT_EN]; // RL14
  assign od_sel[10]   = cfg_pin[10][GPCP_BIT_OPEN_DR];

  // ************************************************************
  // Pad controls and edge detection, one copy per pin
  // ************************************************************

  // Open-drain releases a one instead of driving it, so a line shared
  // with other open-drain parties never fights them
  generate
    for (g = 0; g < GPCP_NUM_PINS; g++)
    begin : g_pin
      assign pin_oe[g]  = drv_sel[g] & ~(od_sel[g] & data_sel[g]); // RL19
      assign pin_out[g] = data_sel[g] & ~od_sel[g]; // RL19
      assign rise[g]    = pin_in[g] & ~prev_in_ff[g];
      assign fall[g]    = ~pin_in[g] & prev_in_ff[g];
    end
  endgenerate

  // Interrupt enables; USB lines lose theirs while USB runs
  generate
    for (g = 0; g < GPCP_NUM_PINS; g++)
    begin : g_ie
      if ((g == GPCP_PIN_P10) || (g == GPCP_PIN_P11))
      begin : g_usb
        assign int_en[g] = ~usb_en & cfg_pin[g][GPCP_BIT_INT_EN]; // RL1
      end
      else
      begin : g_plain
        assign int_en[g] = cfg_pin[g][GPCP_BIT_INT_EN]; // RL17
      end
    end
  endgenerate

  // Pull-ups: the USB pair shares the lift bit of the plus-line register
  assign pin_pullup[0]    = cfg_pin[0][GPCP_BIT_PULLUP];
  assign pin_pullup[1]    = ~usb_en & cfg_pin[1][GPCP_BIT_LIFT_ON]; // RL3
  assign pin_pullup[2]    = ~usb_en & cfg_pin[1][GPCP_BIT_LIFT_ON]; // RL5
  assign pin_pullup[10:3] = {cfg_pin[10][GPCP_BIT_PULLUP],
                             cfg_pin[9][GPCP_BIT_PULLUP],
                             cfg_pin[8][GPCP_BIT_PULLUP],
                             cfg_pin[7][GPCP_BIT_PULLUP],
                             cfg_pin[6][GPCP_BIT_PULLUP],
                             cfg_pin[5][GPCP_BIT_PULLUP],
                             cfg_pin[4][GPCP_BIT_PULLUP],
                             cfg_pin[3][GPCP_BIT_PULLUP]}; // RL10

  // Thresholds: P1.3-P1.7 fixed at TTL, USB pair has no choice
  assign pin_ttl[0]    = cfg_pin[0][GPCP_BIT_TTL];
  assign pin_ttl[2:1]  = 2'h0;
  assign pin_ttl[3]    = cfg_pin[3][GPCP_BIT_TTL];
  assign pin_ttl[8:4]  = 5'h1f; // RL8
  assign pin_ttl[9]    = cfg_pin[9][GPCP_BIT_TTL];
  assign pin_ttl[10]   = cfg_pin[10][GPCP_BIT_TTL];

  // Sink strength and regulator drive where the pin has the option
  assign pin_high_sink[3:0]  = 4'h0;
  assign pin_high_sink[10:4] = {cfg_pin[10][GPCP_BIT_HI_SINK],
                                cfg_pin[9][GPCP_BIT_HI_SINK],
                                cfg_pin[8][GPCP_BIT_HI_SINK],
                                cfg_pin[7][GPCP_BIT_HI_SINK],
                                cfg_pin[6][GPCP_BIT_HI_SINK],
                                cfg_pin[5][GPCP_BIT_HI_SINK],
                                cfg_pin[4][GPCP_BIT_HI_SINK]}; // RL10
  assign pin_drive_3v3[3:0]  = 4'h0;
  assign pin_drive_3v3[7:4]  = {cfg_pin[7][GPCP_BIT_DRV_3V3],
                                cfg_pin[6][GPCP_BIT_DRV_3V3],
                                cfg_pin[5][GPCP_BIT_DRV_3V3],
                                cfg_pin[4][GPCP_BIT_DRV_3V3]}; // RL10
  assign pin_drive_3v3[10:8] = 3'h0;

  // Edge pulses; the input is watched even when the pin drives itself
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_in_ff <= 11'h000;
      irq_ff     <= 11'h000;
    end
    else
    begin
      prev_in_ff <= pin_in;
      for (int p = 0; p < GPCP_NUM_PINS; p++)
      begin
        irq_ff[p] <= int_en[p] & (cfg_pin[p][GPCP_BIT_ACT_LOW]
                                  ? fall[p] : rise[p]); // RL17 RL18
      end
    end
  end
  assign pin_irq = irq_ff;

  // ************************************************************
  // Assertions
  // ************************************************************

  property p_usb_ignore;
    @(posedge hclk) disable iff (!hresetn)
      usb_en |-> (pin_oe[2:1] == 2'h0) && (pin_pullup[2:1] == 2'h0);
  endproperty
  a_usb_ignore: assert property (p_usb_ignore) // RL1
    else $error("USB pair driven while USB enabled");

  property p_plus_no_high;
    @(posedge hclk) disable iff (!hresetn)
      pin_oe[1] |-> !pin_out[1] && !gpio_data[1];
  endproperty
  a_plus_no_high: assert property (p_plus_no_high) // RL2
    else $error("P1.0 drives a high level");

  property p_shared_lift;
    @(posedge hclk) disable iff (!hresetn)
      !usb_en |-> (pin_pullup[1] == cfg_ff[1][1]) &&
                  (pin_pullup[2] == cfg_ff[1][1]);
  endproperty
  a_shared_lift: assert property (p_shared_lift) // RL3
    else $error("USB pair pull-up not from shared bit");

  property p_clk_route;
    @(posedge hclk) disable iff (!hresetn)
      cfg_ff[3][7] |-> pin_oe[3] && (pin_out[3] == clk_src);
  endproperty
  a_clk_route: assert property (p_clk_route) // RL6
    else $error("Clock not on P1.2");

  property p_p13_spi;
    @(posedge hclk) disable iff (!hresetn)
      spi_active && !cfg_ff[4][2] |->
        (pin_oe[4] == spi_oe[0]) && (pin_out[4] == spi_out[0]);
  endproperty
  a_p13_spi: assert property (p_p13_spi) // RL7
    else $error("P1.3 not under serial control");

  property p_ttl_fixed;
    @(posedge hclk) disable iff (!hresetn)
      pin_ttl[8:4] == 5'h1f;
  endproperty
  a_ttl_fixed: assert property (p_ttl_fixed) // RL8
    else $error("P1.3-P1.7 threshold not TTL");

  property p_p14_dir;
    @(posedge hclk) disable iff (!hresetn)
      spi_take[1] && !cfg_ff[5][2] |->
        (pin_oe[5] == cfg_ff[5][0]) && (pin_out[5] == spi_out[1]);
  endproperty
  a_p14_dir: assert property (p_p14_dir) // RL12
    else $error("P1.4 direction not from firmware");

  property p_p15_gpio;
    @(posedge hclk) disable iff (!hresetn)
      !cfg_ff[6][7] && !cfg_ff[6][2] |->
        (pin_oe[6] == cfg_ff[6][0]) && (pin_out[6] == gpio_data[6]);
  endproperty
  a_p15_gpio: assert property (p_p15_gpio) // RL9
    else $error("P1.5 taken without alternate bit");

  property p_open_drain;
    @(posedge hclk) disable iff (!hresetn)
      cfg_ff[0][2] && cfg_ff[0][0] |->
        (pin_oe[0] == !gpio_data[0]) && !pin_out[0];
  endproperty
  a_open_drain: assert property (p_open_drain) // RL19
    else $error("Open-drain P0.7 drives high");

  property p_port2_joint;
    @(posedge hclk) disable iff (!hresetn)
      (pin_pullup[9] == pin_pullup[10]) && (pin_ttl[9] == pin_ttl[10]) &&
      (pin_high_sink[9] == pin_high_sink[10]);
  endproperty
  a_port2_joint: assert property (p_port2_joint) // RL14
    else $error("Port 2 pins configured apart");

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
      wr_pend_ff && (wr_slot_ff == 4'h0) |=> (cfg_ff[0] & 8'h88) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RL13
    else $error("P0.7 reserved bits stored");

  property p_rise_irq;
    @(posedge hclk) disable iff (!hresetn)
      $rose(pin_in[0]) && cfg_ff[0][6] && !cfg_ff[0][5] |=> pin_irq[0];
  endproperty
  a_rise_irq: assert property (p_rise_irq) // RL17
    else $error("Rising edge lost on P0.7");

  property p_fall_irq;
    @(posedge hclk) disable iff (!hresetn)
      $fell(pin_in[8]) && cfg_ff[8][6] && cfg_ff[8][5] |=> pin_irq[8];
  endproperty
  a_fall_irq: assert property (p_fall_irq) // RL18
    else $error("Falling edge lost on P1.7");

  property p_no_irq_off;
    @(posedge hclk) disable iff (!hresetn)
      !cfg_ff[9][6] |=> pin_irq[10:9] == 2'h0;
  endproperty
  a_no_irq_off: assert property (p_no_irq_off) // RL17
    else $error("Interrupt from disabled port 2");

  c_usb_on:  cover property (@(posedge hclk) disable iff (!hresetn)
                             $rose(usb_en));
  c_spi_p15: cover property (@(posedge hclk) disable iff (!hresetn)
                             spi_take[2] && pin_oe[6]);
  c_clk_out: cover property (@(posedge hclk) disable iff (!hresetn)
                             clk_route && pin_oe[3]);
  c_irq:     cover property (@(posedge hclk) disable iff (!hresetn)
                             pin_irq != 11'h000);

endmodule

// ===== gpcp_gpio_pin_config_port_tb.sv
/*
  Self-checking bench: AHB-Lite register tasks, pad checks, edge events.
  Assumes the board model resolves the pads and hready is hreadyout.
*/
module gpcp_gpio_pin_config_port_tb
  import gpcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Signals
  // ************************************************************
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic usb_en = 1'h0, clk_src = 1'h0, hreadyout, hresp, a;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, spi_mode = 2'h0;
  logic [3:0]  spi_oe = 4'hf, spi_out = 4'h7;
  logic [10:0] gpio_data = 11'h0, ext_drv = 11'h0, ext_val = 11'h0;
  logic [10:0] pin_in, pin_out, pin_oe, pin_pullup, pin_ttl;
  logic [10:0] pin_high_sink, pin_drive_3v3, pin_irq;
  int          mismatches = 0, checked = 0, irq_n = 0, base;
  logic [7:0]  mask [10] = '{GPCP_MASK_P0_PIN7, GPCP_MASK_USB_PLUS,
    GPCP_MASK_USB_MINUS, GPCP_MASK_P1_PIN2, GPCP_MASK_P1_PIN3,
    GPCP_MASK_P1_SPI, GPCP_MASK_P1_SPI, GPCP_MASK_P1_SPI,
    GPCP_MASK_P1_PIN7, GPCP_MASK_PORT2};
  // Clock and edge-event counter on P1.7
  always #50 hclk = ~hclk;
  always @(posedge hclk)
    if (pin_irq[GPCP_PIN_P17] === 1'h1)
      irq_n++;
  gpcp_gpio_pin_config_port i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .usb_en(usb_en), .spi_mode(spi_mode), .spi_oe(spi_oe),
    .spi_out(spi_out), .clk_src(clk_src), .gpio_data(gpio_data),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_ttl(pin_ttl),
    .pin_high_sink(pin_high_sink), .pin_drive_3v3(pin_drive_3v3),
    .pin_irq(pin_irq));
  gpcp_board_model i_board (.hclk(hclk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .ext_drv(ext_drv),
    .ext_val(ext_val), .pin_in(pin_in));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic end_sim;
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
    end
  endtask
  // Waits on hready are bounded; the count spans both phases
  task automatic bus(input logic [5:0] idx, input logic w,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 20);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1 && ++n < 40);
    rd = hrdata;
    if (n >= 19)
    begin
      mismatches++;
      end_sim;
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(idx, 1'h1, d);
    #1;
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
    bus(idx, 1'h0, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic wait4;
    repeat (4) @(posedge hclk);
    #1;
  endtask
  // ************************************************************
  // Sequence
  // ************************************************************
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    for (int i = 0; i < 10; i++)
      rdc(GPCP_IDX_FIRST + 6'(i), 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      wr(GPCP_IDX_FIRST + 6'(i), 8'hff);
      rdc(GPCP_IDX_FIRST + 6'(i), mask[i]);
      wr(GPCP_IDX_FIRST + 6'(i), 8'h00);
    end
    wr(6'h16, 8'hff);
    rdc(6'h16, 8'h00);
    // Shared USB pair: open-drain, common pull-up, ignored under USB
    wr(GPCP_IDX_USB_PLUS, 8'h03);
    wr(GPCP_IDX_USB_MINUS, 8'hff);
    chk(32'({pin_oe[2:1], pin_out[2:1]}), 32'hc);
    chk(32'(pin_pullup[2:1]), 32'h3);
    @(posedge hclk) gpio_data <= 11'h006;
    #1 chk(32'(pin_oe[2:1]), 32'h0);
    @(posedge hclk) usb_en <= 1'h1;
    #1 chk(32'({pin_oe[2:1], pin_pullup[2:1]}), 32'h0);
    @(posedge hclk) usb_en <= 1'h0;
    wr(GPCP_IDX_USB_PLUS, 8'h01);
    chk(32'(pin_pullup[2:1]), 32'h0);
    // Clock output on P1.2
    wr(GPCP_IDX_P1_PIN2, 8'h80);
    @(posedge hclk) clk_src <= 1'h1;
    #1 chk(32'({pin_oe[3], pin_out[3]}), 32'h3);
    @(posedge hclk) clk_src <= 1'h0;
    #1 chk(32'({pin_oe[3], pin_out[3]}), 32'h2);
    wr(GPCP_IDX_P1_PIN2, 8'h00);
    chk(32'(pin_oe[3]), 32'h0);
    // Serial takeover across all four role codes, in master and slave only; firmware sets P1.4 per role
    @(posedge hclk) gpio_data <= 11'h000;
    wr(GPCP_IDX_P1_PIN5, 8'h98);
    for (int m = 0; m < 4; m++)
    begin
      wr(GPCP_IDX_P1_PIN4, (m == 2) ? 8'h80 : 8'h81);
      @(posedge hclk) spi_mode <= 2'(m);
      #1 a = (m == 1) || (m == 2);
      chk(32'({pin_oe[7:4], pin_out[6:4]}),
          {25'h0, 1'h0, a, 1'(m != 2), a, a, a, a});
      chk(32'({pin_ttl[8:4], pin_high_sink[6], pin_drive_3v3[7:4]}),
          32'h3f4);
    end
    // Port 2 pair and P0.7 open-drain
    wr(GPCP_IDX_PORT2, 8'h19);
    @(posedge hclk) gpio_data <= 11'h200;
    #1 chk(32'({pin_oe[10:9], pin_out[10:9], pin_ttl[10:9],
               pin_high_sink[10:9]}), 32'hdf);
    wr(GPCP_IDX_P0_PIN7, 8'h05);
    chk(32'({pin_oe[0], pin_out[0]}), 32'h2);
    @(posedge hclk) gpio_data <= 11'h001;
    #1 chk(32'({pin_oe[0], pin_out[0]}), 32'h0);
    wr(GPCP_IDX_P0_PIN7, 8'h01);
    chk(32'({pin_oe[0], pin_out[0]}), 32'h3);
    // Edge events on P1.7: enable off, rising, falling
    @(posedge hclk) ext_drv <= 11'h100;
    // Codes 0x20, 0x40, 0x60: bit 7 of this register is reserved
    for (int k = 0; k < 3; k++)
    begin
      wr(GPCP_IDX_P1_PIN7, 8'(8'h20 * (k + 1)));
      wait4;
      base = irq_n;
      @(posedge hclk) ext_val[8] <= 1'h1;
      wait4;
      chk(32'(irq_n - base), 32'(k == 1));
      @(posedge hclk) ext_val[8] <= 1'h0;
      wait4;
      chk(32'(irq_n - base), 32'(k != 0));
    end
    end_sim;
  end
endmodule

// ===== gpcp_pkg.sv
/*
  Constants shared by the pin configuration bank: register indices,
  write masks, field positions, reset value and pin numbering.
  Assumes a 32-bit AHB-Lite bus with one word per register.
*/
package gpcp_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] GPCP_IDX_P0_PIN7   = 6'h0c;
  localparam logic [5:0] GPCP_IDX_USB_PLUS  = 6'h0d;
  localparam logic [5:0] GPCP_IDX_USB_MINUS = 6'h0e;
  localparam logic [5:0] GPCP_IDX_P1_PIN2   = 6'h0f;
  localparam logic [5:0] GPCP_IDX_P1_PIN3   = 6'h10;
  localparam logic [5:0] GPCP_IDX_P1_PIN4   = 6'h11;
  localparam logic [5:0] GPCP_IDX_P1_PIN5   = 6'h12;
  localparam logic [5:0] GPCP_IDX_P1_PIN6   = 6'h13;
  localparam logic [5:0] GPCP_IDX_P1_PIN7   = 6'h14;
  localparam logic [5:0] GPCP_IDX_PORT2     = 6'h15;
  localparam logic [5:0] GPCP_IDX_FIRST     = GPCP_IDX_P0_PIN7;
  localparam logic [5:0] GPCP_IDX_LAST      = GPCP_IDX_PORT2;
  localparam int         GPCP_NUM_REGS      = 10;

  // ************************************************************
  // Writable bits of each register, reset value
  // ************************************************************
  localparam logic [7:0] GPCP_MASK_P0_PIN7   = 8'h77;
  localparam logic [7:0] GPCP_MASK_USB_PLUS  = 8'he3;
  localparam logic [7:0] GPCP_MASK_USB_MINUS = 8'h65;
  localparam logic [7:0] GPCP_MASK_P1_PIN2   = 8'hf7;
  localparam logic [7:0] GPCP_MASK_P1_PIN3   = 8'h7f;
  localparam logic [7:0] GPCP_MASK_P1_SPI    = 8'hff;
  localparam logic [7:0] GPCP_MASK_P1_PIN7   = 8'h7f;
  localparam logic [7:0] GPCP_MASK_PORT2     = 8'h7f;
  localparam logic [7:0] GPCP_CFG_RESET      = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int GPCP_BIT_ALT      = 7;
  localparam int GPCP_BIT_INT_EN   = 6;
  localparam int GPCP_BIT_ACT_LOW  = 5;
  localparam int GPCP_BIT_TTL      = 4;
  localparam int GPCP_BIT_DRV_3V3  = 4;
  localparam int GPCP_BIT_HI_SINK  = 3;
  localparam int GPCP_BIT_OPEN_DR  = 2;
  localparam int GPCP_BIT_PULLUP   = 1;
  localparam int GPCP_BIT_LIFT_ON  = 1;
  localparam int GPCP_BIT_OUT_EN   = 0;

  // ************************************************************
  // Pin numbering of the pin vectors
  // ************************************************************
  localparam int GPCP_NUM_PINS  = 11;
  localparam int GPCP_PIN_P07   = 0;
  localparam int GPCP_PIN_P10   = 1;
  localparam int GPCP_PIN_P11   = 2;
  localparam int GPCP_PIN_P12   = 3;
  localparam int GPCP_PIN_P13   = 4;
  localparam int GPCP_PIN_P14   = 5;
  localparam int GPCP_PIN_P17   = 8;
  localparam int GPCP_PIN_P20   = 9;
  localparam int GPCP_PIN_P21   = 10;

  // Serial role codes
  localparam logic [1:0] GPCP_SPI_MASTER = 2'h1;
  localparam logic [1:0] GPCP_SPI_SLAVE  = 2'h2;

endpackage
